/* File: rtl/lopm_mixer.sv */
// LED output PWM mixer: Wishbone registers, PWM time bases, group signal, outputs
`timescale 1ns/1ps
module lopm_mixer
   import lopm_pkg::*;
#(
   parameter int unsigned BLINK_UNIT_CYC_P = BLINK_UNIT_CYC
)
(
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  ce_in,
   // Wishbone classic slave
   input  wire logic                  wb_cyc_in,
   input  wire logic                  wb_stb_in,
   input  wire logic                  wb_we_in,
   input  wire logic [WB_ADR_W-1:0]   wb_adr_in,
   input  wire logic [3:0]            wb_sel_in,
   input  wire logic [WB_DAT_W-1:0]   wb_dat_in,
   output      logic [WB_DAT_W-1:0]   wb_dat_out,
   output      logic                  wb_ack_out,
   // Channel output pins
   input  wire logic [NUM_CH-1:0]     channel_output_pin_in,
   output      logic [NUM_CH-1:0]     channel_output_pin_out,
   output      logic [NUM_CH-1:0]     channel_output_pin_oe_n_out
);

   localparam int unsigned UNIT_W = $clog2(BLINK_UNIT_CYC_P);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                  ack_ff;
   logic [WB_DAT_W-1:0]   rd_data_ff;
   logic [WB_DAT_W-1:0]   nxt_rd_data;
   logic                  bus_req;
   logic                  wr_en;
   logic [7:0]            word_adr;
   logic                  duty_hit;
   logic [1:0]            duty_idx;
   logic                  wr_duty;
   logic                  wr_grp_duty;
   logic                  wr_grp_period;
   logic                  wr_ch_state;
   logic                  wr_mode;

   logic [7:0]            channel_duty_ff [NUM_CH];
   logic [7:0]            group_duty_ff;
   logic [7:0]            group_period_ff;
   logic [7:0]            channel_state_register_ff;
   lopm_mode_s            mode_ff;

   logic [STEP_W-1:0]     step_cnt_ff;
   logic                  step_tick;
   logic [PHASE_W-1:0]    phase_ff;

   logic [UNIT_W-1:0]     unit_cnt_ff;
   logic                  unit_tick;
   logic [7:0]            mult_cnt_ff;
   logic                  blink_tick;
   logic [7:0]            blink_phase_ff;

   logic                  grp_sig;
   logic                  fast_blink;
   logic                  dim_grp;
   logic                  fast_grp;
   logic                  slow_grp;
   logic [WB_DAT_W-1:0]   status_word;
   logic [NUM_CH-1:0]     ind_pwm;
   lopm_drive_s           drive [NUM_CH];
   logic [NUM_CH-1:0]     upper_on;
   logic [NUM_CH-1:0]     lower_on;
   logic [NUM_CH-1:0]     pin_seen_ff;

   // ----------------------------------------------------------------
   // Wishbone handshake
   // ----------------------------------------------------------------
   assign bus_req  = wb_cyc_in & wb_stb_in & ~ack_ff;
   assign wr_en    = bus_req & wb_we_in & wb_sel_in[0];
   // Byte offsets below a word boundary select the same register
   assign word_adr = {wb_adr_in[WB_ADR_W-1:2], 2'b00};
   assign duty_hit = (word_adr >= OFS_DUTY0) && (word_adr <= OFS_DUTY3);
   assign duty_idx = word_adr[3:2];

   // ----------------------------------------------------------------
   // Write strobes, one for each writable register; the four duty registers share one
   // ----------------------------------------------------------------
   // Status and unmapped words have no strobe, so writes there are dropped
   assign wr_duty       = wr_en && duty_hit;
   assign wr_grp_duty   = wr_en && (word_adr == OFS_GRP_DUTY);
   assign wr_grp_period = wr_en && (word_adr == OFS_GRP_PERIOD);
   assign wr_ch_state   = wr_en && (word_adr == OFS_CH_STATE);
   assign wr_mode       = wr_en && (word_adr == OFS_MODE);

   // Answers every request one cycle after it is seen, then drops for a cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_ff <= 1'b0;
      end else if (ce_in) begin
         ack_ff <= bus_req;
      end
   end

   // Read data is captured together with the acknowledge
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_ff <= '0;
      end else if (ce_in && bus_req) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign wb_ack_out = ack_ff;
   assign wb_dat_out = rd_data_ff;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            channel_duty_ff[i] <= DUTY_RST;
         end
      end else if (ce_in && wr_duty) begin
         channel_duty_ff[duty_idx] <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         group_duty_ff <= GRP_DUTY_RST;
      end else if (ce_in && wr_grp_duty) begin
         group_duty_ff <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         group_period_ff <= GRP_PERIOD_RST;
      end else if (ce_in && wr_grp_period) begin
         group_period_ff <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         channel_state_register_ff <= CH_STATE_RST;
      end else if (ce_in && wr_ch_state) begin
         channel_state_register_ff <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Totem pole, no inversion, dimming after reset
         mode_ff <= MODE_RST;
      end else if (ce_in && wr_mode) begin
         mode_ff.dim_blink_select  <= wb_dat_in[MODE_DMB_BIT];
         mode_ff.output_invert     <= wb_dat_in[MODE_INV_BIT];
         mode_ff.output_drive_type <= wb_dat_in[MODE_DRV_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Status word: live transistor controls, pin levels, group signal
   // ----------------------------------------------------------------
   always_comb begin
      status_word                           = '0;
      status_word[STAT_LOWER_LSB +: NUM_CH] = lower_on;
      status_word[STAT_UPPER_LSB +: NUM_CH] = upper_on;
      status_word[STAT_PIN_LSB +: NUM_CH]   = pin_seen_ff;
      status_word[STAT_GRP_BIT]             = grp_sig;
   end

   // ----------------------------------------------------------------
   // Read multiplexer; unmapped words read as zero
   // ----------------------------------------------------------------
   always_comb begin
      nxt_rd_data = '0;
      if (duty_hit) begin
         nxt_rd_data[7:0] = channel_duty_ff[duty_idx];
      end else begin
         unique case (word_adr)
            OFS_GRP_DUTY   : nxt_rd_data[7:0] = group_duty_ff;
            OFS_GRP_PERIOD : nxt_rd_data[7:0] = group_period_ff;
            OFS_CH_STATE   : nxt_rd_data[7:0] = channel_state_register_ff;
            OFS_MODE : begin
               nxt_rd_data[MODE_DMB_BIT] = mode_ff.dim_blink_select;
               nxt_rd_data[MODE_INV_BIT] = mode_ff.output_invert;
               nxt_rd_data[MODE_DRV_BIT] = mode_ff.output_drive_type;
            end
            OFS_STATUS     : nxt_rd_data = status_word;
            default : nxt_rd_data = '0;
         endcase
      end
   end

   // Pin levels are sampled so software can read back the wire
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_seen_ff <= '0;
      end else if (ce_in) begin
         pin_seen_ff <= channel_output_pin_in;
      end
   end

   // ----------------------------------------------------------------
   // Individual PWM time base: 2.5 us steps
   // ----------------------------------------------------------------
   // Step length is rounded up to whole clock cycles
   assign step_tick = (step_cnt_ff == STEP_W'(STEP_CYC - 1));

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_cnt_ff <= '0;
      end else if (ce_in) begin
         step_cnt_ff <= step_tick ? '0 : step_cnt_ff + STEP_W'(1);
      end
   end

   // Low 8 bits: 1.5625 kHz frame; low 6: 6.25 kHz; top 4: dimming step
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_ff <= '0;
      end else if (ce_in && step_tick) begin
         phase_ff <= phase_ff + PHASE_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Blink time base: a group step lasts (period + 1) blink units
   // ----------------------------------------------------------------
   // Unit length is a parameter so a test can shorten the blink period
   assign unit_tick  = (unit_cnt_ff == UNIT_W'(BLINK_UNIT_CYC_P - 1));
   assign blink_tick = unit_tick && (mult_cnt_ff >= group_period_ff);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unit_cnt_ff <= '0;
      end else if (ce_in) begin
         unit_cnt_ff <= unit_tick ? '0 : unit_cnt_ff + UNIT_W'(1);
      end
   end

   // A lowered period takes effect at once, without a long wrap-around
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mult_cnt_ff <= '0;
      end else if (ce_in && unit_tick) begin
         mult_cnt_ff <= blink_tick ? 8'h00 : mult_cnt_ff + 8'h01;
      end
   end

   // 256 group steps make one blink period
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         blink_phase_ff <= '0;
      end else if (ce_in && blink_tick) begin
         blink_phase_ff <= blink_phase_ff + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Shared group signal
   // ----------------------------------------------------------------
   // Period values up to the limit blink at 6 Hz or faster
   assign fast_blink = (group_period_ff <= FAST_BLINK_MAX);

   // Dimming: 16 steps, two 6.25 kHz frames per step
   assign dim_grp  = (phase_ff[PHASE_W-1:7] < group_duty_ff[7:4]);
   // Fast blink drops the two low duty bits: 64 steps
   assign fast_grp = (blink_phase_ff < {group_duty_ff[7:2], 2'b00});
   assign slow_grp = (blink_phase_ff < group_duty_ff);

   // Only one group signal exists; the period is ignored while dimming
   always_comb begin
      if (!mode_ff.dim_blink_select) begin
         grp_sig = dim_grp;
      end else if (fast_blink) begin
         grp_sig = fast_grp;
      end else begin
         grp_sig = slow_grp;
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      lopm_chan_state_e ch_state;
      logic             dim_mode;

      assign ch_state = lopm_chan_state_e'(channel_state_register_ff[2*ch +: 2]);
      assign dim_mode = (ch_state == LOPM_ST_GRP) && !mode_ff.dim_blink_select;

      // A group-state channel under dimming runs the individual PWM at 64 steps, otherwise 256
      always_comb begin
         if (dim_mode) begin
            ind_pwm[ch] = (phase_ff[5:0] < channel_duty_ff[ch][7:2]);
         end else begin
            ind_pwm[ch] = (phase_ff[7:0] < channel_duty_ff[ch]);
         end
      end

      // Output flop keeps the pins free of decode glitches
      lopm_out_stage u_out (
         .clk_sys_in   (clk_sys_in),
         .rst_n_in     (rst_n_in),
         .ce_in        (ce_in),
         .state_in     (ch_state),
         .mode_in      (mode_ff),
         .ind_pwm_in   (ind_pwm[ch]),
         .grp_pwm_in   (grp_sig),
         .drive_out    (drive[ch]),
         .pin_out      (channel_output_pin_out[ch]),
         .pin_oe_n_out (channel_output_pin_oe_n_out[ch])
      );

      // Transistor controls feed the status word
      assign upper_on[ch] = drive[ch].upper_on;
      assign lower_on[ch] = drive[ch].lower_on;
   end

endmodule // lopm_mixer

/* File: rtl/lopm_pkg.sv */
// Package: constants, register map and carrier types of the LED output PWM mixer
package lopm_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
   // One individual PWM step in ns; 256 steps give 1.5625 kHz, 64 give 6.25 kHz
   localparam int unsigned STEP_NS        = 2500;
   localparam int unsigned STEP_CYC       = (STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STEP_W         = $clog2(STEP_CYC);
   // Blink period is (period + 1) / 24 s, split into 256 group duty steps
   localparam int unsigned BLINK_BASE_HZ  = 24;
   localparam int unsigned GRP_STEPS      = 256;
   localparam int unsigned BLINK_UNIT_CYC = CLK_HZ / (BLINK_BASE_HZ * GRP_STEPS);
   // Period values up to this one blink at 6 Hz or faster
   localparam logic [7:0]  FAST_BLINK_MAX = 8'h03;
   // Individual phase counter: [5:0] fast step, [6] pair, [10:7] dimming step
   localparam int unsigned PHASE_W        = 11;
   localparam int unsigned NUM_CH         = 4;

   // ----------------------------------------------------------------
   // Wishbone register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam int unsigned WB_ADR_W       = 8;
   localparam int unsigned WB_DAT_W       = 32;
   localparam logic [7:0]  OFS_DUTY0      = 8'h00;
   localparam logic [7:0]  OFS_DUTY3      = 8'h0C;
   localparam logic [7:0]  OFS_GRP_DUTY   = 8'h10;
   localparam logic [7:0]  OFS_GRP_PERIOD = 8'h14;
   localparam logic [7:0]  OFS_CH_STATE   = 8'h18;
   localparam logic [7:0]  OFS_MODE       = 8'h1C;
   localparam logic [7:0]  OFS_STATUS     = 8'h20;

   // Mode register field positions
   localparam int unsigned MODE_DRV_BIT   = 0;
   localparam int unsigned MODE_INV_BIT   = 1;
   localparam int unsigned MODE_DMB_BIT   = 2;

   // Status register field positions
   localparam int unsigned STAT_LOWER_LSB = 0;
   localparam int unsigned STAT_UPPER_LSB = 4;
   localparam int unsigned STAT_PIN_LSB   = 8;
   localparam int unsigned STAT_GRP_BIT   = 12;

   // Values after reset
   localparam logic [7:0]  DUTY_RST       = 8'h00;
   localparam logic [7:0]  GRP_DUTY_RST   = 8'h00;
   localparam logic [7:0]  GRP_PERIOD_RST = 8'h00;
   localparam logic [7:0]  CH_STATE_RST   = 8'h00;
   localparam logic [2:0]  MODE_RST       = 3'h1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LOPM_ST_OFF = 2'b00,
      LOPM_ST_ON  = 2'b01,
      LOPM_ST_IND = 2'b10,
      LOPM_ST_GRP = 2'b11
   } lopm_chan_state_e;

   typedef struct packed {
      logic dim_blink_select;
      logic output_invert;
      logic output_drive_type;
   } lopm_mode_s;

   typedef struct packed {
      logic upper_on;
      logic lower_on;
   } lopm_drive_s;

endpackage

/* File: rtl/lopm_out_stage.sv */
// Per-channel output stage: mixes state, PWM and polarity into transistor controls
`timescale 1ns/1ps
module lopm_out_stage
   import lopm_pkg::*;
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire lopm_chan_state_e state_in,
   input  wire lopm_mode_s       mode_in,
   input  wire logic             ind_pwm_in,
   input  wire logic             grp_pwm_in,
   output      lopm_drive_s      drive_out,
   output      logic             pin_out,
   output      logic             pin_oe_n_out
);

   logic        pwm_on;
   logic        sink_on;
   lopm_drive_s nxt_drive;
   lopm_drive_s drive_ff;

   // ----------------------------------------------------------------
   // Output value before polarity
   // ----------------------------------------------------------------
   always_comb begin
      unique case (state_in)
         LOPM_ST_OFF : pwm_on = 1'b0;
         LOPM_ST_ON  : pwm_on = 1'b1;
         LOPM_ST_IND : pwm_on = ind_pwm_in;
         LOPM_ST_GRP : pwm_on = ind_pwm_in & grp_pwm_in;
      endcase
   end

   // ----------------------------------------------------------------
   // Polarity and drive type
   // ----------------------------------------------------------------
   always_comb begin
      sink_on            = pwm_on ^ mode_in.output_invert;
      nxt_drive.lower_on = sink_on;
      nxt_drive.upper_on = mode_in.output_drive_type & ~sink_on;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drive_ff <= '0;
      end else if (ce_in) begin
         drive_ff <= nxt_drive;
      end
   end

   assign drive_out    = drive_ff;
   assign pin_out      = drive_ff.upper_on;
   assign pin_oe_n_out = ~(drive_ff.upper_on | drive_ff.lower_on);

endmodule // lopm_out_stage

/* File: tb/lopm_mixer_props.sv */
// Checker: port-level properties of the LED output PWM mixer
`timescale 1ns/1ps
module lopm_mixer_props
   import lopm_pkg::*;
#(
   parameter int unsigned BLINK_UNIT_CYC_P = BLINK_UNIT_CYC
)
(
   input  wire logic                clk_sys_in,
   input  wire logic                rst_n_in,
   input  wire logic                ce_in,
   input  wire logic                wb_cyc_in,
   input  wire logic                wb_stb_in,
   input  wire logic                wb_we_in,
   input  wire logic [WB_DAT_W-1:0] wb_dat_out,
   input  wire logic                wb_ack_out,
   input  wire logic [NUM_CH-1:0]   channel_output_pin_out,
   input  wire logic [NUM_CH-1:0]   channel_output_pin_oe_n_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   AST_ACK_LAT: assert property (ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not acknowledged one cycle later");
   AST_ACK_ONE: assert property (ce_in && wb_ack_out |=> !wb_ack_out)
      else $error("acknowledge longer than one cycle");
   AST_ACK_IDLE: assert property (ce_in && !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("acknowledge without request");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
      else $error("acknowledge rose with no request before it");
   AST_RD_UPPER: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[WB_DAT_W-1:13] == '0)
      else $error("read data upper bits not zero");
   AST_DAT_HOLD: assert property (!(wb_cyc_in && wb_stb_in) |=> $stable(wb_dat_out))
      else $error("read data changed without request");

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   AST_UPPER_DRV: assert property ((channel_output_pin_out & channel_output_pin_oe_n_out) == '0)
      else $error("pin drives high while released");
   AST_RST_FLOAT: assert property ($rose(rst_n_in) |->
      channel_output_pin_oe_n_out == '1 && channel_output_pin_out == '0)
      else $error("pins not floating during reset");
   AST_CE_FREEZE: assert property (!ce_in |=> $stable(channel_output_pin_out)
      && $stable(channel_output_pin_oe_n_out) && $stable(wb_ack_out))
      else $error("outputs moved while clock enable low");

   cover property (wb_ack_out && !wb_we_in);
   cover property (!ce_in ##1 ce_in);
   cover property (channel_output_pin_oe_n_out[0] ##1 !channel_output_pin_oe_n_out[0]);
endmodule // lopm_mixer_props

/* File: tb/lopm_led_model.sv */
// Partner model: LEDs tied to supply through resistors, resolving each pin wire
`timescale 1ns/1ps
module lopm_led_model
   import lopm_pkg::*;
(
   input  wire logic [NUM_CH-1:0] pin_drive_in,
   input  wire logic [NUM_CH-1:0] pin_oe_n_in,
   output      logic [NUM_CH-1:0] pin_level_out,
   output      logic [NUM_CH-1:0] led_lit_out
);
   // Resistor to supply pulls a released pin high
   assign pin_level_out = pin_oe_n_in | pin_drive_in;
   // Current flows only while the pin is pulled low
   assign led_lit_out   = ~pin_level_out;
endmodule // lopm_led_model

/* File: tb/lopm_mixer_tb.sv */
// Testbench: bus-driven scenarios for the LED output PWM mixer
`timescale 1ns/1ps
module lopm_mixer_tb;
   import lopm_pkg::*;
   localparam int unsigned BU = 4;
   logic                clk_sys_in, rst_n_in, ce_in, cyc, stb, we, ack, mon_clr, snk, up;
   logic [7:0]          adr;
   logic [3:0]          sel;
   logic [31:0]         wdat, rdat, rv;
   logic [NUM_CH-1:0]   pin_o, pin_oe_n, pin_lvl, lit, sink;
   logic [7:0]          duty_tab [NUM_CH] = '{8'h40, 8'h00, 8'hFF, 8'h01};
   int unsigned         num_errors, checks_done, cycles, ones;
   int unsigned         low_cnt [NUM_CH];
   int unsigned         pulses  [NUM_CH];
   int unsigned         width   [NUM_CH];
   int unsigned         run     [NUM_CH];

   lopm_mixer #(.BLINK_UNIT_CYC_P(BU)) dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .channel_output_pin_in(pin_lvl), .channel_output_pin_out(pin_o),
      .channel_output_pin_oe_n_out(pin_oe_n));

   lopm_led_model u_leds (.pin_drive_in(pin_o), .pin_oe_n_in(pin_oe_n),
      .pin_level_out(pin_lvl), .led_lit_out(lit));

   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // ----------------------------------------------------------------
   // Sink monitor and watchdog
   // ----------------------------------------------------------------
   assign sink = ~pin_oe_n & ~pin_o;
   // Counts on the falling edge so the test sequence never races it
   always @(negedge clk_sys_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (mon_clr) begin
            low_cnt[c] = 0; pulses[c] = 0; run[c] = 0; width[c] = 0;
         end else if (sink[c] === 1'b1) begin
            low_cnt[c]++; run[c]++;
            if (run[c] == 1) pulses[c]++;
         end else begin
            if (run[c] != 0) width[c] = run[c];
            run[c] = 0;
         end
      end
      cycles++;
      if (cycles == 100000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      @(posedge clk_sys_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
      do @(posedge clk_sys_in); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic watch(input int unsigned n);
      mon_clr <= 1'b1;
      @(posedge clk_sys_in);
      mon_clr <= 1'b0;
      repeat (n) @(posedge clk_sys_in);
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0; ce_in = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 8'h00; sel = 4'hF; wdat = 32'h0; mon_clr = 1'b0;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      wb_xfer(1'b0, OFS_MODE, 32'h0, rv); chk(rv, {29'h0, MODE_RST});
      wb_xfer(1'b0, OFS_GRP_PERIOD, 32'h0, rv); chk(rv, 32'h0);
      chk({20'h0, pin_oe_n, pin_o, pin_lvl}, {20'h0, 4'h0, 4'hF, 4'hF});
      wb_xfer(1'b1, 8'h24, 32'h5A, rv);
      wb_xfer(1'b0, 8'h24, 32'h0, rv); chk(rv, 32'h0);
      wb_xfer(1'b1, OFS_STATUS, 32'hFFFF, rv);
      wb_xfer(1'b0, OFS_STATUS, 32'h0, rv); chk({20'h0, rv[11:0]}, 32'hFF0);
      // States 00 and 01 under every drive and polarity setting
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            wb_xfer(1'b1, OFS_MODE, 32'(m), rv);
            wb_xfer(1'b1, OFS_CH_STATE, (s == 1) ? 32'h55 : 32'h00, rv);
            repeat (3) @(posedge clk_sys_in);
            snk = 1'(s) ^ 1'(m >> 1);
            up = 1'(m) & ~snk;
            chk({16'h0, lit, pin_oe_n, pin_o, pin_lvl},
                {16'h0, {4{snk}}, {4{~(snk | up)}}, {4{up}}, {4{~snk}}});
            wb_xfer(1'b0, OFS_STATUS, 32'h0, rv);
            chk({20'h0, rv[11:0]}, {20'h0, {4{~snk}}, {4{up}}, {4{snk}}});
         end
      end
      // Individual PWM alone, group settings ignored
      wb_xfer(1'b1, OFS_MODE, 32'h0, rv);
      for (int c = 0; c < NUM_CH; c++) wb_xfer(1'b1, OFS_DUTY0 + 8'(4 * c), 32'(duty_tab[c]), rv);
      wb_xfer(1'b1, OFS_GRP_DUTY, 32'h0, rv);
      wb_xfer(1'b1, OFS_CH_STATE, 32'hAA, rv);
      wb_xfer(1'b0, OFS_DUTY0, 32'h0, rv); chk(rv, 32'h40);
      watch(GRP_STEPS * STEP_CYC);
      for (int c = 0; c < NUM_CH; c++) chk(32'(low_cnt[c]), 32'(duty_tab[c] * STEP_CYC));
      chk({28'h0, pin_o}, 32'h0);
      wb_xfer(1'b1, OFS_MODE, 32'h2, rv);
      watch(500);
      chk(32'(low_cnt[1]), 32'd500);
      ce_in <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
      ce_in <= 1'b1;
      // Group dimming from a fresh phase origin
      rst_n_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      wb_xfer(1'b1, OFS_MODE, 32'h0, rv);
      for (int c = 0; c < NUM_CH; c++) wb_xfer(1'b1, OFS_DUTY0 + 8'(4 * c), 32'h40, rv);
      wb_xfer(1'b1, OFS_GRP_DUTY, 32'h10, rv);
      wb_xfer(1'b1, OFS_GRP_PERIOD, 32'hFF, rv);
      wb_xfer(1'b1, OFS_CH_STATE, 32'hFF, rv);
      watch(40000);
      for (int c = 0; c < NUM_CH; c++) begin
         chk(32'(pulses[c]), 32'd2);
         chk(32'(width[c]), 32'(16 * STEP_CYC));
      end
      // Blinking: slow then fast rate, sampled every three cycles
      wb_xfer(1'b1, OFS_MODE, 32'h4, rv);
      wb_xfer(1'b1, OFS_GRP_DUTY, 32'h81, rv);
      for (int k = 0; k < 2; k++) begin
         wb_xfer(1'b1, OFS_GRP_PERIOD, (k == 0) ? 32'h5 : 32'h2, rv);
         repeat (200) @(posedge clk_sys_in);
         ones = 0;
         for (int i = 0; i < ((k == 0) ? 2048 : 1024); i++) begin
            wb_xfer(1'b0, OFS_STATUS, 32'h0, rv);
            if (rv[STAT_GRP_BIT] === 1'b1) ones++;
         end
         chk(32'(ones), (k == 0) ? 32'(129 * 6 * BU / 3) : 32'(128 * 3 * BU / 3));
      end
      wrap_up();
   end
endmodule // lopm_mixer_tb

bind lopm_mixer lopm_mixer_props #(.BLINK_UNIT_CYC_P(BLINK_UNIT_CYC_P)) u_props (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .channel_output_pin_out(channel_output_pin_out),
   .channel_output_pin_oe_n_out(channel_output_pin_oe_n_out));
